// [rtl/scp_map.svh]
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
// register indices (printed offsets are not all multiples of four)
`define SCP_IDX_CTRL1       8'h1a
`define SCP_IDX_CTRL2       8'h1b
`define SCP_IDX_MULT_NUM    8'h1c
`define SCP_IDX_MULT_DEN    8'h1d
`define SCP_IDX_CTRL3       8'h1e
`define SCP_IDX_PAGE        8'h1f
`define SCP_IDX_STATUS      8'h20
// page that holds this block
`define SCP_OWN_PAGE        4'h2
// byte address is four times the index
`define SCP_ADDR(idx)       {(idx), 2'b00}
// control two fields
`define SCP_C2_LOAD         7
`define SCP_C2_FIFO_LS      6
`define SCP_C2_WAVE_LS      5
`define SCP_C2_OVR_SECOND   4
`define SCP_C2_OVR_FIRST    3
`define SCP_C2_MAX_RATE     2
// control one fields
`define SCP_C1_SYNC_LINE    1
`define SCP_C1_ENABLE       0
// control three fields
`define SCP_C3_FIFO_RST     7
// reset values
`define SCP_RST_CTRL1       8'h00
`define SCP_RST_CTRL2       8'h02
`define SCP_RST_MULT_NUM    8'h00
`define SCP_RST_MULT_DEN    8'h00
`define SCP_RST_CTRL3       8'h00
`define SCP_RST_PAGE        4'h0
`endif

// [rtl/scp_pkg.sv]
package scp_pkg;
    typedef enum logic [1:0]
    {
        SCP_MODE_OUT_ONLY = 2'b00,
        SCP_MODE_ALL_MULT = 2'b01,
        SCP_MODE_OFF      = 2'b10,
        SCP_MODE_ALL_NOMULT = 2'b11
    } scp_mode_t;

    typedef enum logic [1:0]
    {
        SCP_ST_IDLE  = 2'b00,
        SCP_ST_ARMED = 2'b01,
        SCP_ST_RUN   = 2'b10
    } scp_state_t;

    typedef struct packed
    {
        logic        spread_active;
        logic        modulator_load;
        logic        fifo_reset;
        logic        wave_reset;
        logic        max_modulation_rate;
        logic        first_lock_out;
        logic        second_lock_out;
        scp_mode_t   loop_mode;
        logic        spread_all;
        logic        multiply_en;
        logic [8:0]  numerator;
        logic [8:0]  denominator;
    } scp_ctrl_t;
endpackage

// [rtl/scp_line_sync.sv]
`timescale 1ns/1ps
module scp_line_sync
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // line sync
    input  wire logic       line_sync_input,
    output logic            sync_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // two synchroniser flops plus an edge flop; the first is read by the second only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= line_sync_input;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign sync_pulse = sync_reg & ~prev_reg;
endmodule

// [rtl/scp_holdoff.sv]
`timescale 1ns/1ps
module scp_holdoff
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // trigger and delay
    input  wire logic       start,
    input  wire logic [6:0] delay,
    output logic            fire
);
    logic [6:0] cnt_reg;
    logic       busy_reg;
    logic       fire_reg;

    // restart on every start; zero delay fires on the next edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg  <= 7'h00;
            busy_reg <= 1'b0;
            fire_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg  <= delay;
            busy_reg <= (delay != 7'h00);
            fire_reg <= (delay == 7'h00);
        end
        else if (busy_reg)
        begin
            cnt_reg  <= cnt_reg - 7'h01;
            busy_reg <= (cnt_reg != 7'h01);
            fire_reg <= (cnt_reg == 7'h01);
        end
        else
        begin
            fire_reg <= 1'b0;
        end
    end

    assign fire = fire_reg;
endmodule

// [rtl/scp_top.sv]
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_top
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // line sync and loop lock detectors
    input  wire logic        line_sync_input,
    input  wire logic        first_lock_raw,
    input  wire logic        second_lock_raw,
    // control to the clock unit
    output scp_pkg::scp_ctrl_t ctrl
);
    import scp_pkg::*;

    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] num_reg;
    logic [7:0] den_reg;
    logic [7:0] ctrl3_reg;
    logic [3:0] page_reg;
    logic       enable_prev_reg;
    scp_state_t state_reg;
    scp_state_t state_next;
    scp_ctrl_t  ctrl_reg;
    scp_ctrl_t  ctrl_next;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    wire logic acc      = psel & penable;
    wire logic wr       = acc & pwrite;
    wire logic rd       = acc & ~pwrite;
    wire logic on_page  = (page_reg == `SCP_OWN_PAGE);
    wire logic hit_c1   = (paddr == `SCP_ADDR(`SCP_IDX_CTRL1)) & on_page;
    wire logic hit_c2   = (paddr == `SCP_ADDR(`SCP_IDX_CTRL2)) & on_page;
    wire logic hit_num  = (paddr == `SCP_ADDR(`SCP_IDX_MULT_NUM)) & on_page;
    wire logic hit_den  = (paddr == `SCP_ADDR(`SCP_IDX_MULT_DEN)) & on_page;
    wire logic hit_c3   = (paddr == `SCP_ADDR(`SCP_IDX_CTRL3)) & on_page;
    wire logic hit_pg   = (paddr == `SCP_ADDR(`SCP_IDX_PAGE));
    wire logic hit_st   = (paddr == `SCP_ADDR(`SCP_IDX_STATUS)) & on_page;
    wire logic hit_any  = hit_c1 | hit_c2 | hit_num | hit_den | hit_c3 | hit_pg | hit_st;

    wire logic sync_pulse;
    wire logic holdoff_fire;

    scp_line_sync u_sync
    (
        .pclk            (pclk),
        .presetn         (presetn),
        .line_sync_input (line_sync_input),
        .sync_pulse      (sync_pulse)
    );

    scp_holdoff u_hold
    (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (sync_pulse),
        .delay   (ctrl3_reg[6:0]),
        .fire    (holdoff_fire)
    );

    // one-cycle command strobes; self-clearing bits never store a one
    wire logic load_cmd   = wr & hit_c2 & pwdata[`SCP_C2_LOAD];
    wire logic fifo_cmd   = wr & hit_c3 & pwdata[`SCP_C3_FIFO_RST];
    wire logic enable_now = ctrl1_reg[`SCP_C1_ENABLE];
    wire logic enable_rise = enable_now & ~enable_prev_reg;
    wire logic mode_off   = (scp_mode_t'(ctrl2_reg[1:0]) == SCP_MODE_OFF);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl1_reg <= `SCP_RST_CTRL1;
            ctrl2_reg <= `SCP_RST_CTRL2;
            num_reg   <= `SCP_RST_MULT_NUM;
            den_reg   <= `SCP_RST_MULT_DEN;
            ctrl3_reg <= `SCP_RST_CTRL3;
            page_reg  <= `SCP_RST_PAGE;
        end
        else if (wr)
        begin
            if (hit_c1)
                ctrl1_reg <= {6'h00, pwdata[1:0]};
            if (hit_c2)
                ctrl2_reg <= {1'b0, pwdata[6:0]};
            if (hit_num)
                num_reg <= pwdata[7:0];
            if (hit_den)
                den_reg <= pwdata[7:0];
            if (hit_c3)
                ctrl3_reg <= {1'b0, pwdata[6:0]};
            if (hit_pg)
                page_reg <= pwdata[3:0];
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SCP_ST_IDLE:
                if (enable_rise)
                    state_next = ctrl1_reg[`SCP_C1_SYNC_LINE] ? SCP_ST_ARMED : SCP_ST_RUN;
            SCP_ST_ARMED:
                if (!enable_now)
                    state_next = SCP_ST_IDLE;
                else if (sync_pulse)
                    state_next = SCP_ST_RUN;
            SCP_ST_RUN:
                if (!enable_now)
                    state_next = SCP_ST_IDLE;
            default:
                state_next = SCP_ST_IDLE;
        endcase
    end

    wire logic spread_start = (state_reg != SCP_ST_RUN) & (state_next == SCP_ST_RUN);
    wire logic running      = (state_reg == SCP_ST_RUN);

    always_comb
    begin
        ctrl_next = '0;
        ctrl_next.spread_active = (state_next == SCP_ST_RUN) & ~mode_off;
        // reload on load bit or enable rise
        ctrl_next.modulator_load = load_cmd | enable_rise;
        // fifo reset at start, optional at line sync; forced
        ctrl_next.fifo_reset = fifo_cmd | spread_start
                             | (holdoff_fire & running & ctrl2_reg[`SCP_C2_FIFO_LS]);
        // waveform restart on delayed line sync
        ctrl_next.wave_reset = holdoff_fire & running & ctrl2_reg[`SCP_C2_WAVE_LS];
        ctrl_next.max_modulation_rate = ctrl2_reg[`SCP_C2_MAX_RATE];
        ctrl_next.first_lock_out = first_lock_raw | ctrl2_reg[`SCP_C2_OVR_FIRST];
        ctrl_next.second_lock_out = second_lock_raw | ctrl2_reg[`SCP_C2_OVR_SECOND];
        ctrl_next.loop_mode = scp_mode_t'(ctrl2_reg[1:0]);
        ctrl_next.spread_all = (ctrl2_reg[1:0] == 2'b11) | (ctrl2_reg[1:0] == 2'b01);
        ctrl_next.multiply_en = (ctrl2_reg[1:0] == 2'b01) | (ctrl2_reg[1:0] == 2'b00);
        ctrl_next.numerator = {1'b0, num_reg} + 9'h001;
        ctrl_next.denominator = {1'b0, den_reg} + 9'h001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg       <= SCP_ST_IDLE;
            enable_prev_reg <= 1'b0;
            ctrl_reg        <= '{loop_mode: SCP_MODE_OFF, numerator: 9'h001, denominator: 9'h001, default: '0};
        end
        else
        begin
            state_reg       <= state_next;
            enable_prev_reg <= enable_now;
            ctrl_reg        <= ctrl_next;
        end
    end

    assign ctrl = ctrl_reg;

    // read mux; unmapped addresses, and all but the page register when off page, read zero with pslverr
    wire logic [7:0] rd_byte =
        hit_c1  ? ctrl1_reg :
        hit_c2  ? ctrl2_reg :
        hit_num ? num_reg :
        hit_den ? den_reg :
        hit_c3  ? ctrl3_reg :
        hit_pg  ? {4'h0, page_reg} :
        hit_st  ? {4'h0, ctrl_reg.first_lock_out, ctrl_reg.second_lock_out, state_reg} :
        8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_reg <= ~hit_any;
        end
    end

    // zero wait states: data is set up in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = rd ? prdata_reg : 32'h0000_0000;
    assign pslverr = acc & pslverr_reg;

    sequence s_enable_rise;
        enable_now && !enable_prev_reg;
    endsequence

    sequence s_direct_start;
        s_enable_rise ##0 !ctrl1_reg[`SCP_C1_SYNC_LINE];
    endsequence

    a_load_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        s_enable_rise |=> ctrl.modulator_load)
        else $error("enable rise did not reload modulator");

    a_load_selfclear: assert property (@(posedge pclk) disable iff (!presetn)
        load_cmd |=> !ctrl2_reg[`SCP_C2_LOAD] && ctrl.modulator_load)
        else $error("load bit not self clearing");

    a_fifo_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_direct_start ##0 (state_reg == SCP_ST_IDLE) |=> ctrl.fifo_reset)
        else $error("fifo not reset at spread start");

    a_fifo_no_ls: assert property (@(posedge pclk) disable iff (!presetn)
        holdoff_fire && !ctrl2_reg[`SCP_C2_FIFO_LS] && !fifo_cmd && !spread_start |=> !ctrl.fifo_reset)
        else $error("fifo reset at line sync while disabled");

    a_wave_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.wave_reset |-> $past(ctrl2_reg[`SCP_C2_WAVE_LS]) && $past(holdoff_fire))
        else $error("waveform reset without cause");

    a_second_ovr: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl2_reg[`SCP_C2_OVR_SECOND] |=> ctrl.second_lock_out)
        else $error("second lock override ignored");

    a_first_ovr: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl2_reg[`SCP_C2_OVR_FIRST] |=> ctrl.first_lock_out)
        else $error("first lock override ignored");

    a_num_plus: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl.numerator == {1'b0, $past(num_reg)} + 9'h001)
        else $error("numerator not value plus one");

    a_den_plus: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl.denominator == {1'b0, $past(den_reg)} + 9'h001)
        else $error("denominator not value plus one");

    a_holdoff_zero: assert property (@(posedge pclk) disable iff (!presetn)
        sync_pulse && ctrl3_reg[6:0] == 7'h00 |=> holdoff_fire)
        else $error("zero holdoff did not fire next cycle");

    a_armed_wait: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SCP_ST_ARMED && !sync_pulse && enable_now |=> state_reg == SCP_ST_ARMED)
        else $error("spread began before line sync");

    sequence s_synced_start;
        s_enable_rise ##0 ctrl1_reg[`SCP_C1_SYNC_LINE];
    endsequence

    a_synced_arm: assert property (@(posedge pclk) disable iff (!presetn)
        s_synced_start ##0 (state_reg == SCP_ST_IDLE) |=> state_reg == SCP_ST_ARMED)
        else $error("synced start did not wait for line sync");

    a_direct_run: assert property (@(posedge pclk) disable iff (!presetn)
        s_direct_start ##0 (state_reg == SCP_ST_IDLE) |=> state_reg == SCP_ST_RUN)
        else $error("unsynced start did not run at once");

    a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !running |-> !ctrl.spread_active)
        else $error("spread active while not running");

    a_max_rate: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl.max_modulation_rate == $past(ctrl2_reg[`SCP_C2_MAX_RATE]))
        else $error("max rate output does not follow its bit");

    a_mode_copy: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl.loop_mode == $past(ctrl2_reg[1:0]))
        else $error("loop mode output does not follow its field");

    a_spread_all: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.spread_all == (ctrl.loop_mode == SCP_MODE_ALL_NOMULT || ctrl.loop_mode == SCP_MODE_ALL_MULT))
        else $error("spread all decode wrong");

    a_multiply: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.multiply_en == (ctrl.loop_mode == SCP_MODE_ALL_MULT || ctrl.loop_mode == SCP_MODE_OUT_ONLY))
        else $error("multiply enable decode wrong");

    a_fifo_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_cmd |=> ctrl.fifo_reset && !ctrl3_reg[`SCP_C3_FIFO_RST])
        else $error("fifo reset bit did not reset or clear");

    a_fifo_ls: assert property (@(posedge pclk) disable iff (!presetn)
        holdoff_fire && running && ctrl2_reg[`SCP_C2_FIFO_LS] |=> ctrl.fifo_reset)
        else $error("fifo not reset at line sync");

    a_wave_ls: assert property (@(posedge pclk) disable iff (!presetn)
        holdoff_fire && running && ctrl2_reg[`SCP_C2_WAVE_LS] |=> ctrl.wave_reset)
        else $error("waveform not restarted at line sync");

    // checker helper: cycles since the last synchronized line sync, saturating
    logic [7:0] since_sync_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_sync_reg <= 8'hff;
        else if (sync_pulse)
            since_sync_reg <= 8'h00;
        else if (since_sync_reg != 8'hff)
            since_sync_reg <= since_sync_reg + 8'h01;
    end

    a_holdoff_count: assert property (@(posedge pclk) disable iff (!presetn)
        holdoff_fire |-> since_sync_reg == {1'b0, ctrl3_reg[6:0]})
        else $error("holdoff length differs from setting");

    a_sync_edge: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(line_sync_input) |-> ##2 sync_pulse)
        else $error("line sync edge not synchronized in time");

    a_holdoff_restart: assert property (@(posedge pclk) disable iff (!presetn)
        sync_pulse && ctrl3_reg[6:0] != 7'h00 |=> !holdoff_fire)
        else $error("holdoff not restarted by line sync");
endmodule

// [bench/scp_tb.sv]
`timescale 1ns/1ps
`include "scp_map.svh"
module tb;
    import scp_pkg::*;
    localparam logic [9:0] A_C1  = `SCP_ADDR(`SCP_IDX_CTRL1);
    localparam logic [9:0] A_C2  = `SCP_ADDR(`SCP_IDX_CTRL2);
    localparam logic [9:0] A_NUM = `SCP_ADDR(`SCP_IDX_MULT_NUM);
    localparam logic [9:0] A_DEN = `SCP_ADDR(`SCP_IDX_MULT_DEN);
    localparam logic [9:0] A_C3  = `SCP_ADDR(`SCP_IDX_CTRL3);
    localparam logic [9:0] A_PG  = `SCP_ADDR(`SCP_IDX_PAGE);
    localparam logic [9:0] A_ST  = `SCP_ADDR(`SCP_IDX_STATUS);
    // no register lives here
    localparam logic [9:0] A_BAD = 10'h3fc;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        line_sync_input;
    logic        first_lock_raw;
    logic        second_lock_raw;
    scp_ctrl_t   ctrl;
    logic [31:0] rd;
    logic        err;
    int          error_cnt;
    int          n_checks;
    int          cyc;
    int          n_load;
    int          n_fifo;
    int          n_wave;
    int          t_evt;
    int          t0;
    int          lat0;
    int          b_load;
    int          b_fifo;
    int          b_wave;
    int          ds[4] = '{1, 0, 40, 127};
    int          dd[4] = '{0, -1, 39, 126};
    logic [7:0]  c2v[4] = '{8'h11, 8'h51, 8'h31, 8'h71};

    scp_top DUT (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .line_sync_input (line_sync_input),
        .first_lock_raw  (first_lock_raw),
        .second_lock_raw (second_lock_raw),
        .ctrl            (ctrl)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // pulse counters; snapshots avoid racing the increments
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (ctrl.modulator_load === 1'b1)
            n_load <= n_load + 1;
        if (ctrl.fifo_reset === 1'b1)
        begin
            n_fifo <= n_fifo + 1;
            t_evt  <= cyc;
        end
        if (ctrl.wave_reset === 1'b1)
        begin
            n_wave <= n_wave + 1;
            t_evt  <= cyc;
        end
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd  = prdata;
        err = pslverr;
        if (k >= 50)
            chk({31'h0, pready}, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        repeat (3) @(posedge pclk);
    endtask

    task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask

    task automatic snap();
        b_load = n_load;
        b_fifo = n_fifo;
        b_wave = n_wave;
    endtask

    // synchroniser needs the level held for a few clocks
    task automatic pulse_ls();
        @(posedge pclk);
        t0 = cyc;
        line_sync_input <= 1'b1;
        repeat (4) @(posedge pclk);
        line_sync_input <= 1'b0;
        repeat (150) @(posedge pclk);
    endtask

    initial
    begin
        #100us;
        error_cnt++;
        stop_test();
    end

    initial
    begin
        {psel, penable, pwrite, line_sync_input, first_lock_raw, second_lock_raw} = 6'h0;
        paddr = 10'h0;
        pwdata = 32'h0;
        cyc = 0;
        {n_load, n_fifo, n_wave, t_evt} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk({30'h0, ctrl.loop_mode}, 32'h2);
        chk({23'h0, ctrl.numerator}, 32'h1);
        chk({23'h0, ctrl.denominator}, 32'h1);
        chk({31'h0, ctrl.spread_active}, 32'h0);
        rdc(A_C2, 32'h0, 1'b1);
        wr(A_C2, 8'h03);
        wr(A_PG, {4'h0, `SCP_OWN_PAGE});
        rdc(A_PG, {28'h0, `SCP_OWN_PAGE}, 1'b0);
        rdc(A_C2, 32'h02, 1'b0);
        rdc(A_NUM, 32'h0, 1'b0);
        rdc(A_DEN, 32'h0, 1'b0);
        rdc(A_C3, 32'h0, 1'b0);
        rdc(A_C1, 32'h0, 1'b0);
        rdc(A_BAD, 32'h0, 1'b1);
        wr(A_NUM, 8'hff);
        wr(A_DEN, 8'h00);
        chk({23'h0, ctrl.numerator}, 32'h100);
        chk({23'h0, ctrl.denominator}, 32'h1);
        wr(A_NUM, 8'h0f);
        wr(A_DEN, 8'hfe);
        chk({23'h0, ctrl.numerator}, 32'h10);
        chk({23'h0, ctrl.denominator}, 32'hff);
        rdc(A_DEN, 32'hfe, 1'b0);
        for (int m = 0; m < 4; m++)
        begin
            wr(A_C2, m[7:0]);
            chk({30'h0, ctrl.loop_mode}, m);
            chk({30'h0, ctrl.spread_all, ctrl.multiply_en}, {30'h0, m[0], ~m[1]});
        end
        wr(A_C2, 8'h1d);
        chk({29'h0, ctrl.first_lock_out, ctrl.second_lock_out, ctrl.max_modulation_rate}, 32'h7);
        rdc(A_ST, 32'hc, 1'b0);
        first_lock_raw <= 1'b1;
        wr(A_C2, 8'h01);
        chk({29'h0, ctrl.first_lock_out, ctrl.second_lock_out, ctrl.max_modulation_rate}, 32'h4);
        snap();
        wr(A_C2, 8'h91);
        chk(n_load - b_load, 1);
        rdc(A_C2, 32'h11, 1'b0);
        snap();
        wr(A_C3, 8'h80);
        chk(n_fifo - b_fifo, 1);
        rdc(A_C3, 32'h0, 1'b0);
        snap();
        wr(A_C1, 8'h01);
        chk({31'h0, ctrl.spread_active}, 32'h1);
        chk(n_load - b_load, 1);
        chk(n_fifo - b_fifo, 1);
        rdc(A_ST, 32'h0e, 1'b0);
        wr(A_C3, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_C2, c2v[i]);
            snap();
            pulse_ls();
            chk(n_fifo - b_fifo, {31'h0, c2v[i][6]});
            chk(n_wave - b_wave, {31'h0, c2v[i][5]});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(A_C3, ds[i][7:0]);
            pulse_ls();
            if (i == 0)
                lat0 = t_evt - t0;
            chk(t_evt - t0 - lat0, dd[i]);
        end
        wr(A_C1, 8'h00);
        wr(A_C1, 8'h03);
        chk({31'h0, ctrl.spread_active}, 32'h0);
        rdc(A_ST, 32'h0d, 1'b0);
        pulse_ls();
        chk({31'h0, ctrl.spread_active}, 32'h1);
        rdc(A_ST, 32'h0e, 1'b0);
        stop_test();
    end
endmodule
